// file: ctm_pkg.sv
// Constants, register map and field layout of the compact timer core.
// Assumes a 32-bit APB slave; every register is one aligned word.
// What this block does
// - Bits 2..0 route first-timer pins to timer.
// - Bits 5..3 route second-timer B pins.
// - Ten-bit values split into low/high bytes.
// - Compare low write fills holding buffer only.
// - Compare high write also loads low from buffer.
// - High byte read captures low into buffer.
// - Low byte read returns holding buffer.
// - Modes: compare output, timer/counter, PWM.
// - Ten-bit up-counter on selected clock source.
// - Period bits compare counter top three bits.
// - Compare A checks all ten counter bits.
// - Counter also cleared by on-bit rising.
// - Counter clears on overflow or match.
// - First-timer pins carry true or inverted timer output.
// - Eight byte registers: counter, compare, controls, pin enable, pin invert.
// - Period code times 128, zero means 1024.
// - Mode 00 compare, 10 PWM, 11 timer.
// - Pause bit freezes and resumes the counter.
package ctm_pkg;

    // ****************************************************************
    // Register byte addresses.
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL0    = 8'h00;
    localparam logic [7:0] ADDR_CTRL1    = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO   = 8'h08;
    localparam logic [7:0] ADDR_CNT_HI   = 8'h0C;
    localparam logic [7:0] ADDR_CMPA_LO  = 8'h10;
    localparam logic [7:0] ADDR_CMPA_HI  = 8'h14;
    localparam logic [7:0] ADDR_PIN_EN   = 8'h18;
    localparam logic [7:0] ADDR_PIN_INV  = 8'h1C;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int CTRL0_PAUSE   = 7;
    localparam int CTRL0_CK_HI   = 6;
    localparam int CTRL0_CK_LO   = 4;
    localparam int CTRL0_ON      = 3;
    localparam int CTRL0_RP_HI   = 2;
    localparam int CTRL0_RP_LO   = 0;
    localparam int CTRL1_M_HI    = 7;
    localparam int CTRL1_M_LO    = 6;
    localparam int CTRL1_IO_HI   = 5;
    localparam int CTRL1_IO_LO   = 4;
    localparam int CTRL1_OC      = 3;
    localparam int CTRL1_POL     = 2;
    localparam int CTRL1_CCLR    = 0;
    localparam int CNT_W         = 10;
    localparam int PERIOD_LSB    = 7;
    localparam int FIRST_PINS    = 3;
    localparam int B_PIN_LO      = 3;
    localparam int A_PIN_LO      = 6;

    // ****************************************************************
    // Reset values and constants.
    // ****************************************************************
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [9:0]  CNT_RESET    = 10'h000;
    localparam logic [9:0]  CNT_ONE      = 10'h001;
    localparam logic [6:0]  PERIOD_ZERO  = 7'h00;
    localparam logic [7:0]  DIV4_MASK    = 8'h03;
    localparam logic [7:0]  DIV16_MASK   = 8'h0F;
    localparam logic [7:0]  DIV64_MASK   = 8'h3F;
    localparam logic [7:0]  DIV256_MASK  = 8'hFF;
    localparam logic [7:0]  PRESC_ONE    = 8'h01;

    // Clock source codes.
    localparam logic [2:0] CK_SYS_DIV4  = 3'h0;
    localparam logic [2:0] CK_SYS       = 3'h1;
    localparam logic [2:0] CK_H_DIV16   = 3'h2;
    localparam logic [2:0] CK_H_DIV64   = 3'h3;
    localparam logic [2:0] CK_TBC       = 3'h4;
    localparam logic [2:0] CK_EXT_RISE  = 3'h6;
    localparam logic [2:0] CK_EXT_FALL  = 3'h7;

    // Operating modes and pin actions.
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_PWM     = 2'h2;
    localparam logic [1:0] MODE_TIMER   = 2'h3;
    localparam logic [1:0] IO_NONE      = 2'h0;
    localparam logic [1:0] IO_LOW       = 2'h1;
    localparam logic [1:0] IO_HIGH      = 2'h2;
    localparam logic [1:0] IO_TOGGLE    = 2'h3;

endpackage

// file: ctm_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes only the second flop is read by the caller.
`timescale 1ns/1ns
module ctm_sync (
    input  wire logic ref_clk,   // System clock.
    input  wire logic reset,     // Synchronous reset, active high.
    input  wire logic async_in,  // Level from a pin.
    output logic      sync_out   // Level safe to use.
);
    typedef struct packed {
        logic first;
        logic second;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    // The first flop only feeds the second, to contain metastability.
    always_comb begin
        s_next.first  = async_in;
        s_next.second = s_reg.first;
    end

    // State register.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.second;
endmodule

// file: ctm_core.sv
// Compact 10-bit timer with APB registers and pin-function enables.
// Assumes one 10 MHz clock; the external timer clock is a slow pin.
`timescale 1ns/1ns
module ctm_core (
    input  wire logic        ref_clk,            // System clock.
    input  wire logic        reset,              // Sync reset, high.
    input  wire logic        psel,               // APB select.
    input  wire logic        penable,            // APB enable.
    input  wire logic        pwrite,             // APB direction.
    input  wire logic [7:0]  paddr,              // APB byte address.
    input  wire logic [31:0] pwdata,             // APB write data.
    output logic      [31:0] prdata,             // APB read data.
    output logic             pready,             // APB ready.
    output logic             pslverr,            // APB error.
    input  wire logic        timer_ext_clock_in, // External clock pin.
    input  wire logic [2:0]  second_timer_b_out, // Second timer B outs.
    input  wire logic [1:0]  second_timer_a_out, // Second timer A outs.
    output logic      [7:0]  pin_out,            // Pin output levels.
    output logic      [7:0]  pin_oe,             // Pin timer function.
    output logic             irq_compare_a,      // Comparator A pulse.
    output logic             irq_compare_p       // Comparator P pulse.
);

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  ctrl0;
        logic [7:0]  ctrl1;
        logic [7:0]  pin_en;
        logic [2:0]  pin_inv;
        logic [9:0]  cmpa;
        logic [7:0]  hold;
        logic [9:0]  cnt;
        logic [7:0]  presc;
        logic        on_prev;
        logic        ext_prev;
        logic        tm_out;
        logic        irq_a;
        logic        irq_p;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic [7:0]  pin_out;
        logic [7:0]  pin_oe;
    } core_state_t;

    core_state_t s_reg;
    core_state_t s_next;
    logic        ext_sync;
    logic        setup;
    logic        access;
    logic        tick;
    logic        on_rise;
    logic        a_match;
    logic        p_match;
    logic [9:0]  cnt_inc;
    logic [1:0]  mode;
    logic [1:0]  io_sel;
    logic [2:0]  ck_sel;

    // Zero-extends a byte onto the 32-bit read bus.
    function automatic logic [31:0] word8(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    // True when the prescaler sits at the terminal count of a mask.
    function automatic logic presc_done(input logic [7:0] p,
                                        input logic [7:0] m);
        return (p & m) == m;
    endfunction

    // The external clock pin crosses in through two flops.
    ctm_sync ext_sync_inst (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (timer_ext_clock_in),
        .sync_out (ext_sync)
    );

    // ****************************************************************
    // Decodes shared by the bus and the counter.
    // ****************************************************************
    assign setup   = psel && !penable;
    assign access  = psel && penable && s_reg.ready;
    assign mode    = s_reg.ctrl1[ctm_pkg::CTRL1_M_HI:ctm_pkg::CTRL1_M_LO];
    assign io_sel  = s_reg.ctrl1[ctm_pkg::CTRL1_IO_HI:ctm_pkg::CTRL1_IO_LO];
    assign ck_sel  = s_reg.ctrl0[ctm_pkg::CTRL0_CK_HI:ctm_pkg::CTRL0_CK_LO];
    assign on_rise = s_reg.ctrl0[ctm_pkg::CTRL0_ON] && !s_reg.on_prev;
    assign cnt_inc = s_reg.cnt + ctm_pkg::CNT_ONE;

    // Timer clock select; the divided internal sources share one prescaler.
    always_comb begin
        unique case (ck_sel)
            ctm_pkg::CK_SYS_DIV4:
                tick = presc_done(s_reg.presc, ctm_pkg::DIV4_MASK);
            ctm_pkg::CK_SYS:
                tick = 1'b1;
            ctm_pkg::CK_H_DIV16:
                tick = presc_done(s_reg.presc, ctm_pkg::DIV16_MASK);
            ctm_pkg::CK_H_DIV64:
                tick = presc_done(s_reg.presc, ctm_pkg::DIV64_MASK);
            ctm_pkg::CK_TBC:
                tick = presc_done(s_reg.presc, ctm_pkg::DIV256_MASK);
            ctm_pkg::CK_EXT_RISE:
                tick = ext_sync && !s_reg.ext_prev;
            ctm_pkg::CK_EXT_FALL:
                tick = !ext_sync && s_reg.ext_prev;
            default:
                tick = 1'b0;
        endcase
        tick = tick && s_reg.ctrl0[ctm_pkg::CTRL0_ON]
                    && !s_reg.ctrl0[ctm_pkg::CTRL0_PAUSE];
    end

    // Matches are judged on the value the counter is about to take;
    // period code zero lines up with the wrap, so it means 1024.
    assign p_match = tick
        && cnt_inc[ctm_pkg::CNT_W-1:ctm_pkg::PERIOD_LSB]
           == s_reg.ctrl0[ctm_pkg::CTRL0_RP_HI:ctm_pkg::CTRL0_RP_LO]
        && cnt_inc[ctm_pkg::PERIOD_LSB-1:0]
           == ctm_pkg::PERIOD_ZERO;
    assign a_match = tick && cnt_inc == s_reg.cmpa;

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        s_next          = s_reg;
        s_next.presc    = s_reg.presc + ctm_pkg::PRESC_ONE;
        s_next.ext_prev = ext_sync;
        s_next.on_prev  = s_reg.ctrl0[ctm_pkg::CTRL0_ON];
        s_next.irq_a    = a_match;
        s_next.irq_p    = p_match;

        // Answer in the setup cycle so the access phase ends at once.
        s_next.ready = setup;
        s_next.err   = 1'b0;
        if (setup) begin
            s_next.rdata = '0;
            unique case (paddr)
                ctm_pkg::ADDR_CTRL0:   s_next.rdata = word8(s_reg.ctrl0);
                ctm_pkg::ADDR_CTRL1:   s_next.rdata = word8(s_reg.ctrl1);
                ctm_pkg::ADDR_CNT_LO,
                ctm_pkg::ADDR_CMPA_LO: s_next.rdata = word8(s_reg.hold);
                ctm_pkg::ADDR_CNT_HI:
                    s_next.rdata = word8({6'h00, s_reg.cnt[9:8]});
                ctm_pkg::ADDR_CMPA_HI:
                    s_next.rdata = word8({6'h00, s_reg.cmpa[9:8]});
                ctm_pkg::ADDR_PIN_EN:  s_next.rdata = word8(s_reg.pin_en);
                ctm_pkg::ADDR_PIN_INV:
                    s_next.rdata = word8({5'h00, s_reg.pin_inv});
                default:               s_next.err = 1'b1;
            endcase
            // The counter pair is read-only; software cannot load it.
            if (pwrite && (paddr == ctm_pkg::ADDR_CNT_LO
                        || paddr == ctm_pkg::ADDR_CNT_HI)) begin
                s_next.err = 1'b1;
            end
        end

        // Register effects land on the completing edge only.
        if (access && pwrite) begin
            unique case (paddr)
                ctm_pkg::ADDR_CTRL0:   s_next.ctrl0 = pwdata[7:0];
                ctm_pkg::ADDR_CTRL1:   s_next.ctrl1 = pwdata[7:0];
                ctm_pkg::ADDR_CMPA_LO: s_next.hold = pwdata[7:0];
                ctm_pkg::ADDR_CMPA_HI:
                    s_next.cmpa = {pwdata[1:0], s_reg.hold};
                ctm_pkg::ADDR_PIN_EN:  s_next.pin_en = pwdata[7:0];
                ctm_pkg::ADDR_PIN_INV: s_next.pin_inv = pwdata[2:0];
                default:               s_next.pin_inv = s_reg.pin_inv;
            endcase
        end else if (access) begin
            // A high-byte read freezes the matching low byte.
            if (paddr == ctm_pkg::ADDR_CNT_HI) begin
                s_next.hold = s_reg.cnt[7:0];
            end else if (paddr == ctm_pkg::ADDR_CMPA_HI) begin
                s_next.hold = s_reg.cmpa[7:0];
            end
        end

        // Counter: cleared on switch-on, wrap or the selected match.
        if (on_rise) begin
            s_next.cnt = ctm_pkg::CNT_RESET;
        end else if (tick) begin
            if (s_reg.ctrl1[ctm_pkg::CTRL1_CCLR] ? a_match : p_match) begin
                s_next.cnt = ctm_pkg::CNT_RESET;
            end else begin
                s_next.cnt = cnt_inc;
            end
        end

        // Timer output per mode; the mode change is expected while off.
        unique case (mode)
            ctm_pkg::MODE_COMPARE: begin
                if (on_rise) begin
                    s_next.tm_out = s_reg.ctrl1[ctm_pkg::CTRL1_OC];
                end else if (a_match) begin
                    unique case (io_sel)
                        ctm_pkg::IO_NONE:   s_next.tm_out = s_reg.tm_out;
                        ctm_pkg::IO_LOW:    s_next.tm_out = 1'b0;
                        ctm_pkg::IO_HIGH:   s_next.tm_out = 1'b1;
                        ctm_pkg::IO_TOGGLE: s_next.tm_out = !s_reg.tm_out;
                    endcase
                end
            end
            ctm_pkg::MODE_PWM: begin
                unique case (io_sel)
                    ctm_pkg::IO_NONE:   s_next.tm_out = 1'b0;
                    ctm_pkg::IO_LOW:    s_next.tm_out = 1'b1;
                    ctm_pkg::IO_HIGH:
                        s_next.tm_out = s_reg.cnt < s_reg.cmpa;
                    ctm_pkg::IO_TOGGLE: s_next.tm_out = 1'b0;
                endcase
            end
            ctm_pkg::MODE_TIMER: s_next.tm_out = 1'b0;
            default:             s_next.tm_out = s_reg.tm_out;
        endcase

        // Pins: enabled ones carry a timer, the rest keep other use.
        for (int i = 0; i < ctm_pkg::FIRST_PINS; i++) begin
            s_next.pin_out[i] = s_reg.pin_en[i]
                && (s_reg.tm_out ^ s_reg.ctrl1[ctm_pkg::CTRL1_POL]
                    ^ s_reg.pin_inv[i]);
        end
        s_next.pin_out[5:3] = s_reg.pin_en[5:3] & second_timer_b_out;
        s_next.pin_out[7:6] = s_reg.pin_en[7:6] & second_timer_a_out;
        s_next.pin_oe = s_reg.pin_en;
    end

    // ****************************************************************
    // State register; every register clears on reset.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata        = s_reg.rdata;
    assign pready        = s_reg.ready;
    assign pslverr       = s_reg.err;
    assign pin_out       = s_reg.pin_out;
    assign pin_oe        = s_reg.pin_oe;
    assign irq_compare_a = s_reg.irq_a;
    assign irq_compare_p = s_reg.irq_p;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence wr_lo_s;
        access && pwrite && paddr == ctm_pkg::ADDR_CMPA_LO;
    endsequence

    chk_hold_write: assert property (wr_lo_s |=> s_reg.hold
        == $past(pwdata[7:0]) && s_reg.cmpa == $past(s_reg.cmpa))
        else $error("Compare low write did not go to the buffer.");

    // A high write takes whatever the buffer holds, however it got there.
    sequence wr_hi_s;
        access && pwrite && paddr == ctm_pkg::ADDR_CMPA_HI;
    endsequence

    chk_cmpa_load: assert property (
        wr_hi_s
        |=> s_reg.cmpa == {$past(pwdata[1:0]), $past(s_reg.hold)})
        else $error("Compare high write did not load both bytes.");

    chk_hold_capture: assert property (
        access && !pwrite && paddr == ctm_pkg::ADDR_CNT_HI
        |=> s_reg.hold == $past(s_reg.cnt[7:0]))
        else $error("Counter high read did not capture the low byte.");

    chk_low_read: assert property (
        setup && !pwrite && paddr == ctm_pkg::ADDR_CNT_LO
        |=> pready && prdata[7:0] == $past(s_reg.hold))
        else $error("Low read did not return the buffer.");

    chk_on_clear: assert property (on_rise |=> s_reg.cnt == '0)
        else $error("Switch-on did not clear the counter.");

    chk_pause_freeze: assert property (
        s_reg.ctrl0[ctm_pkg::CTRL0_PAUSE] && !on_rise
        |=> s_reg.cnt == $past(s_reg.cnt))
        else $error("Counter moved while paused.");

    // Back-to-back matches are legal, so only an isolated one is judged.
    chk_irq_pulse: assert property (
        a_match ##1 !a_match |-> irq_compare_a ##1 !irq_compare_a)
        else $error("Compare A interrupt is not a single pulse.");

    chk_period_clear: assert property (
        p_match && !s_reg.ctrl1[ctm_pkg::CTRL1_CCLR] && !on_rise
        |=> s_reg.cnt == '0 && irq_compare_p)
        else $error("Period match did not clear the counter.");

    chk_pin_enable: assert property (
        ##1 pin_oe == $past(s_reg.pin_en)
        && (pin_out & ~pin_oe) == 8'h00)
        else $error("Pin enable and pin drive disagree.");
endmodule

// file: testbench.sv
// Self-checking bench for the compact timer core and its pin enables.
// Assumes ctm_pkg and ctm_core are compiled first; one 10 MHz clock.
`timescale 1ns/1ns
module testbench;

    // ****************************************************************
    // Signals and bookkeeping.
    // ****************************************************************
    logic        ref_clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer_ext_clock_in;
    logic [2:0]  second_timer_b_out;
    logic [1:0]  second_timer_a_out;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic        irq_compare_a;
    logic        irq_compare_p;
    int          num_errors;
    int          n_tests;
    int          cycles;
    int          seed;
    int          n;
    logic [31:0] rd;
    logic [31:0] v;
    logic [31:0] w;
    logic        er;
    logic [7:0]  p0;
    logic [9:0]  c1;
    logic [9:0]  c2;
    logic [9:0]  c3;
    logic [7:0]  regs [6] = '{ctm_pkg::ADDR_CTRL0, ctm_pkg::ADDR_CTRL1,
        ctm_pkg::ADDR_CNT_HI, ctm_pkg::ADDR_CMPA_HI, ctm_pkg::ADDR_PIN_EN,
        ctm_pkg::ADDR_PIN_INV};
    logic [1:0]  modes [3] = '{ctm_pkg::MODE_COMPARE, ctm_pkg::MODE_PWM,
        ctm_pkg::MODE_TIMER};
    logic [2:0]  codes [3] = '{3'h1, 3'h3, 3'h0};

    ctm_core dut (
        .ref_clk            (ref_clk),
        .reset              (reset),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .timer_ext_clock_in (timer_ext_clock_in),
        .second_timer_b_out (second_timer_b_out),
        .second_timer_a_out (second_timer_a_out),
        .pin_out            (pin_out),
        .pin_oe             (pin_oe),
        .irq_compare_a      (irq_compare_a),
        .irq_compare_p      (irq_compare_p)
    );

    // Free-running system clock, 100 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Hang guard; the longest scenario needs well under 20000 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            results();
        end
    end

    // ****************************************************************
    // Tasks and expectation functions.
    // ****************************************************************
    // Closing report, the only place the run ends.
    task automatic results();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // One APB transfer; held until pready is seen high at a rising edge.
    // Releasing costs one idle cycle so no signal is driven twice a step.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        if (k >= 20) begin
            num_errors++;
            $display("BAD %0t no ready", $time);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read data");
    endtask

    // Counter read in the order that keeps the byte pair coherent.
    task automatic rdcnt(output logic [9:0] c);
        apb(1'b0, ctm_pkg::ADDR_CNT_HI, 32'h0);
        c[9:8] = rd[1:0];
        apb(1'b0, ctm_pkg::ADDR_CNT_LO, 32'h0);
        c[7:0] = rd[7:0];
    endtask

    function automatic logic irq(input logic sel_p);
        return sel_p ? irq_compare_p : irq_compare_a;
    endfunction

    // Waits for a pulse, checks it lasts one cycle, counts to the next.
    task automatic gap(input logic sel_p, output int len);
        int k;
        k = 0;
        while (irq(sel_p) !== 1'b1 && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
        @(posedge ref_clk);
        chk(32'(irq(sel_p)), 32'h0, "pulse width");
        len = 1;
        while (irq(sel_p) !== 1'b1 && len < 3000) begin
            @(posedge ref_clk);
            len++;
        end
    endtask

    function automatic logic [31:0] c0(input logic p, input logic [2:0] ck,
                                       input logic on, input logic [2:0] rp);
        return {24'h0, p, ck, on, rp};
    endfunction

    // A code of zero lets the counter run through its full ten bits.
    function automatic logic [31:0] period_len(input logic [2:0] code);
        return (code == 3'h0) ? 32'h400 : 32'h80 * code;
    endfunction

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        seed = 4;
        num_errors = 0;
        n_tests = 0;
        cycles = 0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        timer_ext_clock_in = 1'b0;
        second_timer_b_out = 3'h0;
        second_timer_a_out = 2'h0;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        // Every register but the two low bytes reads back cleared after reset.
        foreach (regs[i]) rdchk(regs[i], 32'h0);
        // Pin enables, all-ones first, then random patterns.
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'hFFFF : $random(seed);
            second_timer_b_out <= v[10:8];
            second_timer_a_out <= v[12:11];
            apb(1'b1, ctm_pkg::ADDR_PIN_EN, {24'h0, v[7:0]});
            repeat (3) @(posedge ref_clk);
            chk(32'(pin_oe), 32'(v[7:0]), "pin enable");
            chk(32'(pin_out[7:3]), 32'(v[7:3] & v[12:8]), "b a pins");
            rdchk(ctm_pkg::ADDR_PIN_EN, {24'h0, v[7:0]});
        end
        // Inversion flips exactly the selected first-timer pins.
        apb(1'b1, ctm_pkg::ADDR_PIN_EN, 32'hFF);
        repeat (3) @(posedge ref_clk);
        p0 = pin_out;
        apb(1'b1, ctm_pkg::ADDR_PIN_INV, 32'h5);
        repeat (3) @(posedge ref_clk);
        chk(32'(pin_out[2:0]), 32'(p0[2:0] ^ 3'h5), "inverted pin");
        // Each of the three defined mode codes is stored and read back with random fields.
        foreach (modes[i]) begin
            v = $random(seed);
            v = {24'h0, modes[i], v[5:0]};
            apb(1'b1, ctm_pkg::ADDR_CTRL1, v);
            rdchk(ctm_pkg::ADDR_CTRL1, v);
        end
        apb(1'b1, ctm_pkg::ADDR_CTRL1, 32'h0);
        // Counter is read-only; a stray address is refused.
        apb(1'b1, ctm_pkg::ADDR_CNT_HI, 32'h3);
        chk(32'(er), 32'h1, "counter write");
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(er), 32'h1, "unmapped error");
        // Buffered byte pairs; a lone low write must not reach the value.
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            w = $random(seed);
            apb(1'b1, ctm_pkg::ADDR_CMPA_LO, {24'h0, v[7:0]});
            apb(1'b1, ctm_pkg::ADDR_CMPA_HI, {30'h0, v[9:8]});
            rdchk(ctm_pkg::ADDR_CMPA_HI, {30'h0, v[9:8]});
            rdchk(ctm_pkg::ADDR_CMPA_LO, {24'h0, v[7:0]});
            apb(1'b1, ctm_pkg::ADDR_CMPA_LO, {24'h0, w[7:0]});
            rdchk(ctm_pkg::ADDR_CMPA_HI, {30'h0, v[9:8]});
            rdchk(ctm_pkg::ADDR_CMPA_LO, {24'h0, v[7:0]});
        end
        // Period match; the first gap after a change may be short.
        foreach (codes[i]) begin
            apb(1'b1, ctm_pkg::ADDR_CTRL0,
                c0(1'b0, ctm_pkg::CK_SYS, 1'b1, codes[i]));
            gap(1'b1, n);
            gap(1'b1, n);
            chk(32'(n), period_len(codes[i]), "period");
        end
        // Comparator A against a free-running ten-bit count.
        gap(1'b0, n);
        gap(1'b0, n);
        chk(32'(n), 32'h400, "compare a gap");
        // PWM on pin 1: high for as many cycles per wrap as the compare.
        apb(1'b1, ctm_pkg::ADDR_CTRL1,
            {24'h0, ctm_pkg::MODE_PWM, ctm_pkg::IO_HIGH, 4'h0});
        repeat (4) @(posedge ref_clk);
        n = 0;
        repeat (1024) begin
            @(posedge ref_clk);
            n += pin_out[1];
        end
        chk(32'(n), 32'(v[9:0]), "pwm duty");
        apb(1'b1, ctm_pkg::ADDR_CTRL1, 32'h0);
        // Pause holds the count, release resumes from it.
        apb(1'b1, ctm_pkg::ADDR_CTRL0, c0(1'b1, ctm_pkg::CK_SYS, 1'b1, 3'h0));
        rdcnt(c1);
        repeat (30) @(posedge ref_clk);
        rdcnt(c2);
        chk(32'(c2), 32'(c1), "paused count");
        apb(1'b1, ctm_pkg::ADDR_CTRL0, c0(1'b0, ctm_pkg::CK_SYS, 1'b1, 3'h0));
        rdcnt(c3);
        c3 = c3 - c1;
        chk(32'(c3 > 10'h000 && c3 < 10'h014), 32'h1, "resume");
        // Off then on clears the count; pin edges then drive it.
        apb(1'b1, ctm_pkg::ADDR_CTRL0,
            c0(1'b0, ctm_pkg::CK_EXT_RISE, 1'b0, 3'h0));
        apb(1'b1, ctm_pkg::ADDR_CTRL0,
            c0(1'b0, ctm_pkg::CK_EXT_RISE, 1'b1, 3'h0));
        repeat (4) @(posedge ref_clk);
        repeat (20) begin
            timer_ext_clock_in <= 1'b1;
            repeat (4) @(posedge ref_clk);
            timer_ext_clock_in <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        rdcnt(c1);
        chk(32'(c1), 32'h14, "pin clock count");
        results();
    end

endmodule
